/* File: rtl/skt_decoder.sv */
// Decoder for the bit, carry and port skip tests and the timer 1 load.
`timescale 1ns/10ps
`default_nettype none
`include "skt_cfg.svh"

module skt_decoder
    import skt_pkg::*;
(
    // Clock and reset.
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    // Instruction stream and core state.
    input  wire skt_instr_t i_instr,
    input  wire skt_core_t  i_core,
    // Port pins, asynchronous.
    input  wire logic [3:0] i_port_pins,
    // Sequencing towards the core.
    output logic            o_skip_pending,
    output logic            o_second_word,
    output logic            o_timer1_load,
    // Timer 1 values.
    output skt_timer_t      o_timer1
);

    skt_state_t state_reg;
    skt_state_t state_next;
    logic       skip_pending_next;
    logic       load_next;
    logic [7:0] load_value_reg;
    logic [7:0] load_value_next;
    logic [3:0] port_meta_reg;
    logic [3:0] port_sync_reg;
    logic       take;
    logic       mem_bit;
    logic       port_bit;

    // Port pins pass two flip-flops before any test reads them.
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            port_meta_reg <= `SKT_PORT_RESET;
            port_sync_reg <= `SKT_PORT_RESET;
        end
        else
        begin
            port_meta_reg <= i_port_pins;
            port_sync_reg <= port_meta_reg;
        end
    end

    // A word that arrives while a skip is pending is the skipped one.
    assign take     = i_instr.valid && !o_skip_pending;
    assign mem_bit  = i_core.mem_nibble[i_instr.code[`SKT_BIT_SEL_MSB:
                                                     `SKT_BIT_SEL_LSB]];
    assign port_bit = port_sync_reg[i_core.index[1:0]];

    always_comb
    begin
        state_next        = state_reg;
        skip_pending_next = o_skip_pending;
        load_next         = 1'b0;
        load_value_next   = load_value_reg;
        if (i_instr.valid && o_skip_pending)
        begin
            skip_pending_next = 1'b0;
        end
        else if (take)
        begin
            unique case (state_reg)
                SKT_ST_IDLE:
                begin
                    if ((i_instr.code & `SKT_OP_MEM_BIT_MASK) ==
                        `SKT_OP_MEM_BIT_BASE)
                    begin
                        skip_pending_next = !mem_bit;
                    end
                    else if (i_instr.code == `SKT_OP_CARRY)
                    begin
                        skip_pending_next = !i_core.carry;
                    end
                    else if (i_instr.code == `SKT_OP_PORT_FIRST)
                    begin
                        state_next = SKT_ST_WORD2;
                    end
                    else if (i_instr.code == `SKT_OP_TIMER1_LOAD)
                    begin
                        load_next       = 1'b1;
                        load_value_next = {i_core.reg_b,
                                           i_core.acc};
                    end
                end
                SKT_ST_WORD2:
                begin
                    state_next = SKT_ST_IDLE;
                    if (i_instr.code == `SKT_OP_PORT_SECOND &&
                        i_core.index <= `SKT_PORT_INDEX_MAX)
                    begin
                        skip_pending_next = !port_bit;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_reg <= SKT_ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_skip_pending <= 1'b0;
        end
        else
        begin
            o_skip_pending <= skip_pending_next;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_second_word <= 1'b0;
        end
        else
        begin
            o_second_word <= (state_next == SKT_ST_WORD2);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_timer1_load  <= 1'b0;
            load_value_reg <= `SKT_TIMER_RESET;
        end
        else
        begin
            o_timer1_load  <= load_next;
            load_value_reg <= load_value_next;
        end
    end

    skt_timer1_regs u_timer1 (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_load    (o_timer1_load),
        .i_value   (load_value_reg),
        .o_timer   (o_timer1)
    );

    chk_mem_bit_skip: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b)
        take && state_reg == SKT_ST_IDLE &&
        (i_instr.code & `SKT_OP_MEM_BIT_MASK) == `SKT_OP_MEM_BIT_BASE
        |=> o_skip_pending == !$past(mem_bit))
        else $error("memory bit test gave the wrong skip");

    chk_carry_skip: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b)
        take && state_reg == SKT_ST_IDLE &&
        i_instr.code == `SKT_OP_CARRY
        |=> o_skip_pending == !$past(i_core.carry) && !o_timer1_load)
        else $error("carry test gave the wrong skip");

    chk_port_skip: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b)
        take && i_instr.code == `SKT_OP_PORT_FIRST &&
        state_reg == SKT_ST_IDLE
        ##1 take && i_instr.code == `SKT_OP_PORT_SECOND &&
        i_core.index <= `SKT_PORT_INDEX_MAX
        |=> o_skip_pending == !$past(port_bit) && !o_second_word)
        else $error("port bit test gave the wrong skip");

    chk_port_nop: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b)
        take && state_reg == SKT_ST_WORD2 &&
        i_core.index > `SKT_PORT_INDEX_MAX
        |=> !o_skip_pending && !o_second_word)
        else $error("port test with large index did not act as a nop");

    chk_load_upper: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b)
        take && state_reg == SKT_ST_IDLE &&
        i_instr.code == `SKT_OP_TIMER1_LOAD
        |=> o_timer1_load ##1
        o_timer1.count[7:4] == $past(i_core.reg_b, 2) &&
        o_timer1.reload[7:4] == $past(i_core.reg_b, 2))
        else $error("timer 1 upper nibble not loaded from B");

    chk_load_lower: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b)
        take && state_reg == SKT_ST_IDLE &&
        i_instr.code == `SKT_OP_TIMER1_LOAD
        |-> ##2 o_timer1.count[3:0] == $past(i_core.acc, 2) &&
        o_timer1.reload[3:0] == $past(i_core.acc, 2))
        else $error("timer 1 lower nibble not loaded from A");

    chk_skip_consumes: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b)
        o_skip_pending && i_instr.valid
        |=> !o_skip_pending && !o_timer1_load && !o_second_word
        ##1 $stable(o_timer1))
        else $error("skipped instruction had an effect");

    chk_skip_holds: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b)
        o_skip_pending && !i_instr.valid |=> o_skip_pending)
        else $error("pending skip dropped without a word");

endmodule : skt_decoder

`default_nettype wire

/* File: include/skt_cfg.svh */
// Opcodes, field positions and reset values for the skip and timer-load decoder.
`ifndef SKT_CFG_SVH
`define SKT_CFG_SVH

`define SKT_OP_MEM_BIT_BASE   10'h020
`define SKT_OP_MEM_BIT_MASK   10'h3fc
`define SKT_OP_CARRY          10'h02f
`define SKT_OP_PORT_FIRST     10'h024
`define SKT_OP_PORT_SECOND    10'h02b
`define SKT_OP_TIMER1_LOAD    10'h230
`define SKT_BIT_SEL_MSB       1
`define SKT_BIT_SEL_LSB       0
`define SKT_PORT_INDEX_MAX    4'h3
`define SKT_TIMER_RESET       8'h00
`define SKT_PORT_RESET        4'h0

`endif

/* File: include/skt_pkg.sv */
// Types shared by the skip and timer-load decoder.
package skt_pkg;

    typedef struct packed {
        logic       valid;
        logic [9:0] code;
    } skt_instr_t;

    typedef struct packed {
        logic [3:0] mem_nibble;
        logic       carry;
        logic [3:0] index;
        logic [3:0] acc;
        logic [3:0] reg_b;
    } skt_core_t;

    typedef struct packed {
        logic [7:0] count;
        logic [7:0] reload;
    } skt_timer_t;

    typedef enum logic [0:0] {
        SKT_ST_IDLE  = 1'b0,
        SKT_ST_WORD2 = 1'b1
    } skt_state_t;

endpackage : skt_pkg

/* File: rtl/skt_timer1_regs.sv */
// Timer 1 count and reload holding registers with a parallel load.
`timescale 1ns/10ps
`default_nettype none
`include "skt_cfg.svh"

module skt_timer1_regs
    import skt_pkg::*;
(
    // Clock and reset.
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    // Load request.
    input  wire logic       i_load,
    input  wire logic [7:0] i_value,
    // Held values.
    output skt_timer_t      o_timer
);

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_timer.count  <= `SKT_TIMER_RESET;
            o_timer.reload <= `SKT_TIMER_RESET;
        end
        else if (i_load)
        begin
            o_timer.count  <= i_value;
            o_timer.reload <= i_value;
        end
    end

endmodule : skt_timer1_regs

`default_nettype wire

/* File: verif/skip_and_timer_load_instructions_tb.sv */
// Self-checking bench for the skip and timer-load decoder.
`timescale 1ns/10ps
`default_nettype none
`include "skt_cfg.svh"

module skip_and_timer_load_instructions_tb
    import skt_pkg::*;
;
    typedef struct packed {
        logic        skip;
        logic        second;
        logic        load;
        logic [15:0] tmr;
    } skt_note_t;

    logic        i_clk_sys = 1'b0;
    logic        i_rst_b   = 1'b0;
    skt_instr_t  instr     = '0;
    skt_core_t   core      = '0;
    logic [3:0]  pins      = 4'h0;
    logic        skip_p;
    logic        second_w;
    logic        t_load;
    skt_timer_t  tmr;
    int          n_mismatch = 0;
    int          n_tests    = 0;
    int          cycles     = 0;
    logic [15:0] lfsr       = 16'h1990;
    logic        m_skip     = 1'b0;
    logic        m_second   = 1'b0;
    logic [15:0] m_tmr      = 16'h0000;
    logic        taken      = 1'b0;
    skt_note_t   notes[$];
    logic [9:0]  ops[9] = '{10'h020, 10'h021, 10'h022, 10'h023, 10'h02f,
                            10'h024, 10'h02b, 10'h230, 10'h000};

    skt_decoder u_dut (
        .i_clk_sys      (i_clk_sys),
        .i_rst_b        (i_rst_b),
        .i_instr        (instr),
        .i_core         (core),
        .i_port_pins    (pins),
        .o_skip_pending (skip_p),
        .o_second_word  (second_w),
        .o_timer1_load  (t_load),
        .o_timer1       (tmr)
    );

    always #2.5 i_clk_sys = ~i_clk_sys;

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    task automatic next_rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    endtask : next_rnd

    task automatic chk_bit(input logic got, input logic exp,
                           input string what);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : chk_bit

    task automatic chk_timer(input skt_timer_t got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: timer value", $time);
        end
    endtask : chk_timer

    // The model decides each word's effect and queues the expectation.
    task automatic send(input logic [9:0] code, input skt_core_t c);
        skt_note_t n;
        n     = '0;
        n.tmr = m_tmr;
        if (m_skip)
            m_skip = 1'b0;
        else if (m_second)
        begin
            if (code == `SKT_OP_PORT_SECOND && c.index <= `SKT_PORT_INDEX_MAX)
                n.skip = ~pins[c.index[1:0]];
        end
        else if ((code & `SKT_OP_MEM_BIT_MASK) == `SKT_OP_MEM_BIT_BASE)
            n.skip = ~c.mem_nibble[code[1:0]];
        else if (code == `SKT_OP_CARRY)
            n.skip = ~c.carry;
        else if (code == `SKT_OP_PORT_FIRST)
            n.second = 1'b1;
        else if (code == `SKT_OP_TIMER1_LOAD)
        begin
            n.load = 1'b1;
            m_tmr  = {2{c.reg_b, c.acc}};
        end
        m_skip   = n.skip;
        m_second = n.second;
        notes.push_back(n);
        instr = '{1'b1, code};
        core  = c;
        @(negedge i_clk_sys);
    endtask : send

    task automatic idle(input int k);
        instr.valid = 1'b0;
        repeat (k) @(negedge i_clk_sys);
    endtask : idle

    always @(posedge i_clk_sys)
        taken <= i_rst_b && instr.valid;

    always @(negedge i_clk_sys)
    begin
        skt_note_t n;
        if (taken && notes.size() > 0)
        begin
            n = notes.pop_front();
            chk_bit(skip_p, n.skip, "skip flag");
            chk_bit(second_w, n.second, "second word");
            chk_bit(t_load, n.load, "load pulse");
            chk_timer(tmr, n.tmr);
        end
    end

    always @(posedge i_clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial
    begin
        skt_core_t  c;
        logic [9:0] op;
        repeat (6) @(negedge i_clk_sys);
        i_rst_b = 1'b1;
        pins    = 4'h5;
        idle(3);
        // A load, then a skipped load that must leave the timer alone.
        c = '0;
        c.acc   = 4'ha;
        c.reg_b = 4'h5;
        send(`SKT_OP_TIMER1_LOAD, c);
        send(10'h022, c);
        c.acc = 4'h3;
        send(`SKT_OP_TIMER1_LOAD, c);
        send(10'h000, c);
        for (int b = 0; b < 8; b++)
        begin
            next_rnd();
            pins = lfsr[3:0];
            idle(3);
            for (int i = 0; i < 40; i++)
            begin
                next_rnd();
                op = ops[lfsr % 9];
                if (lfsr[15])
                    idle(1);
                next_rnd();
                c[16:8] = lfsr[8:0];
                next_rnd();
                c[7:0] = lfsr[7:0];
                send(op, c);
                if (op == `SKT_OP_PORT_FIRST)
                    send(`SKT_OP_PORT_SECOND, c);
            end
        end
        idle(3);
        give_verdict();
    end
endmodule : skip_and_timer_load_instructions_tb
`default_nettype wire
